//--- hdl/sss_params.svh
// Constants for the station status byte block
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
`define SSS_B2_DEACT 7
`define SSS_B2_RSVD 6
`define SSS_B2_SYNC 5
`define SSS_B2_FREEZE 4
`define SSS_B2_WD 3
`define SSS_B2_SLAVE 2
`define SSS_B2_STAT 1
`define SSS_B2_PRM 0
`define SSS_B3_OVF 7
`define SSS_BYTE_RST 8'h00
`define SSS_CNT_W 8
`define SSS_DIAG_CAP 8'h08
`define SSS_TEL_CAP 8'h04
`define SSS_CNT_ZERO 8'h00
`define SSS_CNT_ONE 8'h01
`endif

//--- hdl/sss_pkg.sv
// Types for the station status byte block
package sss_pkg;
    typedef logic [7:0] sss_byte_t;
    typedef enum logic [1:0] {
        SSS_IDLE = 2'b00,
        SSS_WAIT = 2'b01,
        SSS_ANSWER = 2'b10
    } sss_state_t;
endpackage : sss_pkg

//--- hdl/sss_diag_if.sv
// Diagnostic exchange between slave status logic and master
`timescale 1ns/1ps
`default_nettype none
interface sss_diag_if;
    import sss_pkg::*;
    logic diag_req;
    logic diag_ack;
    sss_byte_t stat2;
    sss_byte_t stat3;
    logic deact;
    modport slave_end (input diag_req, input deact, output diag_ack, output stat2, output stat3);
    modport master_end (output diag_req, output deact, input diag_ack, input stat2, input stat3);
endinterface : sss_diag_if
`default_nettype wire

//--- hdl/sss_sticky.sv
// Sticky flag: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sss_sticky
    import sss_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Sync reset, low
    input wire logic set, // Set pulse
    input wire logic clr, // Clear pulse
    output logic flag // Held flag
);
    logic next_flag;
    always_comb begin
        next_flag = flag;
        if (clr) begin
            next_flag = 1'b0;
        end
        if (set) begin
            next_flag = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule : sss_sticky
`default_nettype wire

//--- hdl/sss_slave_end.sv
// Slave end: builds station status bytes two and three
`timescale 1ns/1ps
`default_nettype none
`include "sss_params.svh"
module sss_slave_end
    import sss_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Sync reset, low
    sss_diag_if.slave_end dx, // Link to master
    input wire logic sync_cmd, // Sync command pulse
    input wire logic freeze_cmd, // Freeze command pulse
    input wire logic unsync_cmd, // Unsync command pulse
    input wire logic unfreeze_cmd, // Unfreeze command pulse
    input wire logic wd_enable, // Watchdog enabled level
    input wire logic not_ready, // General error level
    input wire logic prm_need, // Needs new parameters level
    input wire logic prm_done, // Parameterisation done pulse
    input wire logic chan_add, // New channel entry pulse
    input wire logic chan_rem, // Entry reported pulse
    output logic overflow // Overflow flag
);
    // Sticky command and request flags
    logic sync_flag;
    logic freeze_flag;
    logic prm_flag;

    // Pending channel entries
    logic [`SSS_CNT_W-1:0] pend;
    logic [`SSS_CNT_W-1:0] next_pend;
    logic add_only;
    logic rem_only;
    logic pend_full;
    logic pend_empty;
    logic tel_over;
    logic buf_over;
    logic next_overflow;

    // Reply path
    sss_byte_t live_stat2;
    sss_byte_t live_stat3;
    sss_byte_t next_stat2;
    sss_byte_t next_stat3;
    logic next_ack;

    // Set wins over clear, so a command meeting its undo still lands
    sss_sticky u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .set(sync_cmd),
        .clr(unsync_cmd),
        .flag(sync_flag)
    );

    sss_sticky u_freeze (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .set(freeze_cmd),
        .clr(unfreeze_cmd),
        .flag(freeze_flag)
    );

    // Held until the master confirms a fresh parameter set
    sss_sticky u_prm (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .set(prm_need),
        .clr(prm_done),
        .flag(prm_flag)
    );

    // Add and remove in one cycle cancel
    assign add_only = chan_add && !chan_rem;
    assign rem_only = chan_rem && !chan_add;
    assign pend_full = (pend == {`SSS_CNT_W{1'b1}});
    assign pend_empty = (pend == `SSS_CNT_ZERO);

    // Count saturates both ways rather than wrapping into a false clear
    always_comb begin
        next_pend = pend;
        if (add_only && !pend_full) begin
            next_pend = pend + `SSS_CNT_ONE;
        end else if (rem_only && !pend_empty) begin
            next_pend = pend - `SSS_CNT_ONE;
        end
        tel_over = (next_pend > `SSS_TEL_CAP);
        buf_over = (next_pend > `SSS_DIAG_CAP);
        // Telegram limit is the lower one, so it decides in practice
        next_overflow = tel_over || buf_over;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pend <= `SSS_CNT_ZERO;
            overflow <= 1'b0;
        end else begin
            pend <= next_pend;
            overflow <= next_overflow;
        end
    end

    // Live status; reserved positions are never written high
    always_comb begin
        live_stat2 = `SSS_BYTE_RST;
        live_stat3 = `SSS_BYTE_RST;
        live_stat2[`SSS_B2_DEACT] = dx.deact;
        live_stat2[`SSS_B2_RSVD] = 1'b0;
        live_stat2[`SSS_B2_SYNC] = sync_flag;
        live_stat2[`SSS_B2_FREEZE] = freeze_flag;
        live_stat2[`SSS_B2_WD] = wd_enable;
        live_stat2[`SSS_B2_SLAVE] = 1'b1;
        live_stat2[`SSS_B2_STAT] = not_ready;
        live_stat2[`SSS_B2_PRM] = prm_flag;
        live_stat3[`SSS_B3_OVF] = overflow;
    end

    // One answer per request, one cycle later
    always_comb begin
        next_ack = 1'b0;
        if (dx.diag_req) begin
            next_ack = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dx.diag_ack <= 1'b0;
        end else begin
            dx.diag_ack <= next_ack;
        end
    end

    // Bytes are taken once per request so a reply is self-consistent
    always_comb begin
        next_stat2 = dx.stat2;
        if (dx.diag_req) begin
            next_stat2 = live_stat2;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dx.stat2 <= `SSS_BYTE_RST;
        end else begin
            dx.stat2 <= next_stat2;
        end
    end

    // Byte three follows the same request as byte two
    always_comb begin
        next_stat3 = dx.stat3;
        if (dx.diag_req) begin
            next_stat3 = live_stat3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dx.stat3 <= `SSS_BYTE_RST;
        end else begin
            dx.stat3 <= next_stat3;
        end
    end
endmodule : sss_slave_end
`default_nettype wire

//--- hdl/sss_master_end.sv
// Master end: polls slave diagnostics and decides exchange
`timescale 1ns/1ps
`default_nettype none
`include "sss_params.svh"
module sss_master_end
    import sss_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Sync reset, low
    sss_diag_if.master_end dx, // Link to slave
    input wire logic poll, // Request a diagnostic pulse
    input wire logic slave_inactive, // Parameter set marks inactive
    output logic data_exch_en, // Cyclic exchange allowed
    output logic reparam, // Start parameterisation pulse
    output logic more_diag, // Overflow seen
    output sss_byte_t last_stat2, // Last byte two
    output logic busy // Waiting for answer
);
    sss_state_t state;
    sss_state_t next_state;
    logic next_exch;
    logic next_reparam;
    logic next_more;
    sss_byte_t next_last;
    logic req_r;
    logic next_req;

    assign dx.diag_req = req_r;
    assign dx.deact = slave_inactive;
    assign busy = (state != SSS_IDLE);

    always_comb begin
        next_state = state;
        next_exch = data_exch_en;
        next_reparam = 1'b0;
        next_more = more_diag;
        next_last = last_stat2;
        next_req = 1'b0;
        if (slave_inactive) begin
            next_exch = 1'b0;
        end
        case (state)
            SSS_IDLE: begin
                if (poll) begin
                    next_req = 1'b1;
                    next_state = SSS_WAIT;
                end
            end
            SSS_WAIT: begin
                if (dx.diag_ack) begin
                    next_state = SSS_ANSWER;
                end
            end
            SSS_ANSWER: begin
                next_last = dx.stat2;
                next_more = dx.stat3[`SSS_B3_OVF];
                next_reparam = dx.stat2[`SSS_B2_PRM];
                next_exch = !slave_inactive && !dx.stat2[`SSS_B2_STAT] && !dx.stat2[`SSS_B2_PRM];
                // Keep polling while static diagnostic stands
                next_req = dx.stat2[`SSS_B2_STAT];
                next_state = dx.stat2[`SSS_B2_STAT] ? SSS_WAIT : SSS_IDLE;
            end
            default: begin
                next_state = SSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= SSS_IDLE;
            data_exch_en <= 1'b0;
            reparam <= 1'b0;
            more_diag <= 1'b0;
            last_stat2 <= `SSS_BYTE_RST;
            req_r <= 1'b0;
        end else begin
            state <= next_state;
            data_exch_en <= next_exch;
            reparam <= next_reparam;
            more_diag <= next_more;
            last_stat2 <= next_last;
            req_r <= next_req;
        end
    end
endmodule : sss_master_end
`default_nettype wire

//--- dv/sss_monitor.sv
// Checker on the diagnostic exchange signals
`timescale 1ns/1ps
`default_nettype none
module sss_monitor
    import sss_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Sync reset, low
    input wire logic diag_req, // Request
    input wire logic diag_ack, // Answer
    input wire sss_byte_t stat2, // Byte two
    input wire sss_byte_t stat3, // Byte three
    input wire logic deact // Inactive level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_taken; diag_req; endsequence
    sequence s_answer; ##1 diag_ack ##1 !diag_ack; endsequence
    a_ack_follows: assert property (s_taken |-> s_answer) else $error("answer missing");
    a_ack_cause: assert property (diag_ack |-> $past(diag_req)) else $error("answer without request");
    a_req_spaced: assert property (diag_req |=> !diag_req [*2]) else $error("requests too close");
    a_slave_bit: assert property (diag_ack |-> stat2[2]) else $error("marker low");
    a_rsvd_zero: assert property (diag_ack |-> !stat2[6] && stat3[6:0] == 7'h00) else $error("reserved set");
    a_deact_bit: assert property (diag_ack |-> stat2[7] == $past(deact)) else $error("deact mismatch");
    a_bytes_stand: assert property (!diag_ack |-> $stable(stat2) && $stable(stat3)) else $error("bytes moved");
    a_static_poll: assert property (diag_ack && stat2[1] |-> ##[1:3] diag_req) else $error("no repoll");
endmodule : sss_monitor
`default_nettype wire

//--- dv/sss_tb.sv
// Bench joining slave and master ends
`timescale 1ns/1ps
`default_nettype none
module sss_tb;
    import sss_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, poll = 1'b0, slave_inactive = 1'b0, sync_cmd = 1'b0, freeze_cmd = 1'b0;
    logic unsync_cmd = 1'b0, unfreeze_cmd = 1'b0, wd_enable = 1'b0, not_ready = 1'b0, prm_need = 1'b0;
    logic prm_done = 1'b0, chan_add = 1'b0, chan_rem = 1'b0, rp_seen = 1'b0;
    logic overflow, data_exch_en, reparam, more_diag, busy;
    sss_byte_t last_stat2;
    int err_total = 0, compares = 0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (reparam === 1'b1) rp_seen <= 1'b1;
    sss_diag_if dx();
    sss_slave_end i_sss_slave_end (.core_clk(core_clk), .rst_b(rst_b), .dx(dx), .sync_cmd(sync_cmd),
        .freeze_cmd(freeze_cmd), .unsync_cmd(unsync_cmd), .unfreeze_cmd(unfreeze_cmd), .wd_enable(wd_enable),
        .not_ready(not_ready), .prm_need(prm_need), .prm_done(prm_done), .chan_add(chan_add),
        .chan_rem(chan_rem), .overflow(overflow));
    sss_master_end i_sss_master_end (.core_clk(core_clk), .rst_b(rst_b), .dx(dx), .poll(poll),
        .slave_inactive(slave_inactive), .data_exch_en(data_exch_en), .reparam(reparam),
        .more_diag(more_diag), .last_stat2(last_stat2), .busy(busy));
    sss_monitor i_sss_monitor (.core_clk(core_clk), .rst_b(rst_b), .diag_req(dx.diag_req),
        .diag_ack(dx.diag_ack), .stat2(dx.stat2), .stat3(dx.stat3), .deact(dx.deact));
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask : pulse
    // Poll ignored while busy, so wait out the whole walk
    task automatic ask(input logic [7:0] e2, input logic en);
        poll = 1'b1;
        step(1);
        poll = 1'b0;
        chk("busy", 8'h01, {7'h00, busy});
        step(8);
        chk("stat2", e2, last_stat2);
        chk("exch", {7'h00, en}, {7'h00, data_exch_en});
    endtask : ask
    initial begin
        step(2);
        rst_b = 1'b1;
        step(1);
        ask(8'h04, 1'b1);
        pulse(sync_cmd);
        pulse(freeze_cmd);
        wd_enable = 1'b1;
        ask(8'h3C, 1'b1);
        sync_cmd = 1'b1;
        unsync_cmd = 1'b1;
        unfreeze_cmd = 1'b1;
        pulse(freeze_cmd);
        {sync_cmd, unsync_cmd, unfreeze_cmd} = 3'h0;
        ask(8'h3C, 1'b1);
        pulse(unfreeze_cmd);
        ask(8'h2C, 1'b1);
        not_ready = 1'b1;
        ask(8'h2E, 1'b0);
        not_ready = 1'b0;
        ask(8'h2C, 1'b1);
        chk("reparam0", 8'h00, {7'h00, rp_seen});
        pulse(prm_need);
        ask(8'h2D, 1'b0);
        chk("reparam", 8'h01, {7'h00, rp_seen});
        pulse(prm_done);
        ask(8'h2C, 1'b1);
        slave_inactive = 1'b1;
        step(2);
        ask(8'hAC, 1'b0);
        slave_inactive = 1'b0;
        chan_add = 1'b1;
        step(4);
        chan_add = 1'b0;
        step(1);
        chk("ovf4", 8'h00, {7'h00, overflow});
        pulse(chan_add);
        step(1);
        chk("ovf5", 8'h01, {7'h00, overflow});
        ask(8'h2C, 1'b1);
        chk("more", 8'h01, {7'h00, more_diag});
        pulse(chan_rem);
        step(1);
        chk("ovf", 8'h00, {7'h00, overflow});
        ask(8'h2C, 1'b1);
        chk("more0", 8'h00, {7'h00, more_diag});
        chk("idle", 8'h00, {7'h00, busy});
        test_done();
    end
    initial begin
        step(2000);
        err_total++;
        test_done();
    end
endmodule : sss_tb
`default_nettype wire
